// ### fbt_pkg.sv
package fbt_pkg;

	// ****************************************
	// Geometry and limits
	// ****************************************
	localparam int unsigned BLOCK_WORDS = 128;
	localparam logic [6:0] LAST_WORD = 7'h7F;
	localparam logic [10:0] MAX_BLK_SMALL = 11'd999;
	localparam logic [10:0] MAX_BLK_LARGE = 11'd1999;
	localparam int unsigned DM_WORDS_DEF = 6656;
	localparam int unsigned PM_WORDS_DEF = 32768;
	localparam logic [15:0] END_WORD_DEF = 16'h0001;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_DONE = 8'h04;
	localparam logic [7:0] OFS_LEFT = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_BLOCK = 8'h14;
	localparam logic [7:0] OFS_WORD = 8'h18;
	localparam logic [7:0] OFS_CFG = 8'h1C;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned ST_CLR = 0;
	localparam int unsigned ST_ACTIVE = 1;
	localparam int unsigned ST_DIR = 2;
	localparam int unsigned ST_FERR = 3;
	localparam int unsigned ST_ERR = 7;
	localparam int unsigned CMD_EDGE = 2;
	localparam int unsigned CMD_COND = 3;
	localparam int unsigned CFG_CAP2000 = 0;
	localparam int unsigned CFG_ROM = 1;
	localparam int unsigned CFG_IND = 2;
	localparam int unsigned FE_ABSENT = 0;
	localparam int unsigned FE_BCD = 1;
	localparam int unsigned FE_RANGE = 2;
	localparam int unsigned FE_MEM = 3;
	localparam logic [15:0] RST_WORD = 16'h0000;

	typedef enum logic [1:0] {
		FBT_OP_NONE = 2'b00,
		FBT_OP_READ = 2'b01,
		FBT_OP_WRITE = 2'b10,
		FBT_OP_LOAD = 2'b11
	} fbt_op_e;

	typedef enum logic [3:0] {
		FBT_IDLE = 4'b0000,
		FBT_CHECK = 4'b0001,
		FBT_BSTART = 4'b0010,
		FBT_SRC = 4'b0011,
		FBT_SWAIT = 4'b0100,
		FBT_DST = 4'b0101,
		FBT_DWAIT = 4'b0110,
		FBT_NEXT = 4'b0111,
		FBT_BLK = 4'b1000,
		FBT_DONE = 4'b1001
	} fbt_state_e;

	// ****************************************
	// BCD helpers
	// ****************************************
	function automatic logic fbt_is_bcd(input logic [15:0] v);
		fbt_is_bcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) &&
			(v[11:8] < 4'hA) && (v[15:12] < 4'hA);
	endfunction

	function automatic logic [13:0] fbt_bcd2bin(input logic [15:0] v);
		fbt_bcd2bin = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 +
			14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
	endfunction

	function automatic logic [15:0] fbt_bcd_step(input logic [15:0] v,
			input logic up);
		logic [15:0] r;
		logic go;
		r = v;
		go = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (go) begin
				if (up) begin
					go = (r[i*4 +: 4] == 4'h9);
					r[i*4 +: 4] = go ? 4'h0 : r[i*4 +: 4] + 4'h1;
				end else begin
					go = (r[i*4 +: 4] == 4'h0);
					r[i*4 +: 4] = go ? 4'h9 : r[i*4 +: 4] - 4'h1;
				end
			end
		end
		fbt_bcd_step = r;
	endfunction

endpackage

// ### fbt_sync2.sv
`timescale 1ns/1ps
module fbt_sync2 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} fbt_sync_s;

	fbt_sync_s s_q;
	fbt_sync_s s_d;

	always_comb begin
		s_d.s1 = d;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.s2;
endmodule // fbt_sync2

// ### fbt_bcd_counter.sv
`timescale 1ns/1ps
module fbt_bcd_counter
	import fbt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic step,
	input wire logic up,
	output logic [15:0] value
);
	typedef struct packed {
		logic [15:0] v;
	} fbt_cnt_s;

	fbt_cnt_s s_q;
	fbt_cnt_s s_d;

	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.v = load_val;
		end else if (step) begin
			s_d.v = fbt_bcd_step(s_q.v, up);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.v <= RST_WORD;
		end else begin
			s_q <= s_d;
		end
	end

	assign value = s_q.v;
endmodule // fbt_bcd_counter

// ### fbt_engine.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
// What this block does
// - File memory is moved in whole 128-word blocks, except when a failure stops a block read.
// - Capacity is 1000 or 2000 blocks, numbered from zero.
// - Transfer-active flag stays high while any block transfer runs.
// - Direction flag high out of file memory, low into it.
// - Error-clear bit driven high then low resets the file error flags.
// - Four-digit BCD count of blocks transferred so far.
// - Four-digit BCD count of blocks still to transfer in a block read or write.
// - Block read copies N blocks from source block into data memory.
// - Block read drops words that do not fit in the data area.
// - On failure a block read finishes the current word, then stops.
// - Block read flags error: unit absent, bad BCD, last block too high.
// - Block write copies N blocks from data memory into file memory.
// - Short last source block leaves rest of file block empty.
// - On power failure a block write finishes the current block.
// - Block write flags error: unit absent, bad BCD, last block too high.
// - Indirect operand not BCD or past its area raises the error flag.
// - Program load copies blocks from the load point, then runs them.
// - Load stops at block with end instruction or next non-program block.
// - Load always finishes the whole final block.
// - Load flags error: ROM memory, absent, bad start, does not fit.
module fbt_engine
	import fbt_pkg::*;
#(
	parameter int unsigned DM_WORDS = DM_WORDS_DEF,
	parameter int unsigned PM_WORDS = PM_WORDS_DEF,
	parameter logic [15:0] END_WORD = END_WORD_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fm_present,
	input wire logic fm_fail,
	output logic fm_req,
	output logic fm_we,
	output logic [17:0] fm_addr,
	output logic [15:0] fm_wdata,
	input wire logic [15:0] fm_rdata,
	input wire logic fm_rprog,
	input wire logic fm_ack,
	output logic wm_req,
	output logic wm_we,
	output logic wm_space,
	output logic [15:0] wm_addr,
	output logic [15:0] wm_wdata,
	input wire logic [15:0] wm_rdata,
	input wire logic wm_ack,
	output logic run_loaded,
	output logic [15:0] run_addr,
	output logic xfer_active,
	output logic xfer_dir
);
	import fbt_pkg::*;

	typedef struct packed {
		fbt_state_e st;
		fbt_op_e op;
		logic edge_mode;
		logic cond;
		logic cond_prev;
		logic pend;
		logic clr;
		logic clr_prev;
		logic [2:0] cfg;
		logic [15:0] n_bcd;
		logic [15:0] blk_bcd;
		logic [15:0] waddr;
		logic active;
		logic dir;
		logic [3:0] ferr;
		logic err;
		logic [10:0] blk;
		logic [13:0] left;
		logic [6:0] word;
		logic [15:0] wptr;
		logic [15:0] data;
		logic first;
		logic end_seen;
		logic abort;
		logic fm_req;
		logic fm_we;
		logic [17:0] fm_addr;
		logic [15:0] fm_wdata;
		logic wm_req;
		logic wm_we;
		logic wm_space;
		logic [15:0] wm_addr;
		logic [15:0] wm_wdata;
		logic run_pend;
		logic run_pulse;
		logic [15:0] run_addr;
		logic cnt_ld;
		logic cnt_step;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} fbt_engine_s;

	fbt_engine_s s_q;
	fbt_engine_s s_d;
	logic present_s;
	logic fail_s;
	logic err_set;
	logic [15:0] done_cnt;
	logic [15:0] left_cnt;
	logic [10:0] max_blk;
	logic [13:0] n_bin;
	logic [13:0] blk_bin;
	logic [14:0] last_blk;
	logic [15:0] eff_addr;
	logic [16:0] area;
	logic [3:0] bad;

	// ****************************************
	// Pin synchronisers and counters
	// ****************************************
	fbt_sync2 u_sync_present (.pclk(pclk), .presetn(presetn),
		.d(fm_present), .q(present_s));
	fbt_sync2 u_sync_fail (.pclk(pclk), .presetn(presetn),
		.d(fm_fail), .q(fail_s));

	fbt_bcd_counter u_done (.pclk(pclk), .presetn(presetn),
		.load(s_q.cnt_ld), .load_val(RST_WORD), .step(s_q.cnt_step),
		.up(1'b1), .value(done_cnt));
	fbt_bcd_counter u_left (.pclk(pclk), .presetn(presetn),
		.load(s_q.cnt_ld),
		.load_val(s_q.op == FBT_OP_LOAD ? RST_WORD : s_q.n_bcd),
		.step(s_q.cnt_step && s_q.op != FBT_OP_LOAD),
		.up(1'b0), .value(left_cnt));

	// ****************************************
	// Operand checks
	// ****************************************
	always_comb begin
		max_blk = s_q.cfg[CFG_CAP2000] ? MAX_BLK_LARGE : MAX_BLK_SMALL;
		n_bin = fbt_bcd2bin(s_q.n_bcd);
		blk_bin = fbt_bcd2bin(s_q.blk_bcd);
		last_blk = 15'(blk_bin) + 15'(n_bin) - 15'd1;
		area = (s_q.op == FBT_OP_LOAD) ? 17'(PM_WORDS) : 17'(DM_WORDS);
		eff_addr = s_q.cfg[CFG_IND] ? 16'(fbt_bcd2bin(s_q.waddr)) : s_q.waddr;
		bad = '0;
		bad[FE_ABSENT] = !present_s;
		bad[FE_BCD] = !fbt_is_bcd(s_q.blk_bcd) ||
			(s_q.op != FBT_OP_LOAD && !fbt_is_bcd(s_q.n_bcd));
		bad[FE_RANGE] = (s_q.op == FBT_OP_LOAD) ?
			(15'(blk_bin) > 15'(max_blk)) :
			(n_bin != '0 && last_blk > 15'(max_blk));
		bad[FE_MEM] = (s_q.op == FBT_OP_LOAD && s_q.cfg[CFG_ROM]) ||
			(s_q.cfg[CFG_IND] && (!fbt_is_bcd(s_q.waddr) ||
			17'(eff_addr) >= area));
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		err_set = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.run_pulse = 1'b0;
		s_d.cnt_ld = 1'b0;
		s_d.cnt_step = 1'b0;
		s_d.cond_prev = s_q.cond;
		s_d.clr_prev = s_q.clr;
		if (s_q.edge_mode && s_q.cond && !s_q.cond_prev) begin
			s_d.pend = 1'b1;
		end
		if (psel && penable && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.prdata = '0;
			case (paddr)
				OFS_STATUS: s_d.prdata[7:0] = {s_q.err, s_q.ferr, s_q.dir,
					s_q.active, s_q.clr};
				OFS_DONE: s_d.prdata[15:0] = done_cnt;
				OFS_LEFT: s_d.prdata[15:0] = left_cnt;
				OFS_CMD: s_d.prdata[3:0] = {s_q.cond, s_q.edge_mode, s_q.op};
				OFS_COUNT: s_d.prdata[15:0] = s_q.n_bcd;
				OFS_BLOCK: s_d.prdata[15:0] = s_q.blk_bcd;
				OFS_WORD: s_d.prdata[15:0] = s_q.waddr;
				OFS_CFG: s_d.prdata[2:0] = s_q.cfg;
				default: s_d.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && s_q.pready && pwrite) begin
			case (paddr)
				OFS_STATUS: s_d.clr = pwdata[ST_CLR];
				OFS_CMD: begin
					s_d.op = fbt_op_e'(pwdata[1:0]);
					s_d.edge_mode = pwdata[CMD_EDGE];
					s_d.cond = pwdata[CMD_COND];
				end
				OFS_COUNT: s_d.n_bcd = pwdata[15:0];
				OFS_BLOCK: s_d.blk_bcd = pwdata[15:0];
				OFS_WORD: s_d.waddr = pwdata[15:0];
				OFS_CFG: s_d.cfg = pwdata[2:0];
				default: s_d.cfg = s_q.cfg;
			endcase
		end
		if (s_q.clr_prev && !s_q.clr) begin
			s_d.ferr = '0;
			s_d.err = 1'b0;
		end
		if (s_q.run_pend && (s_q.edge_mode || !s_q.cond)) begin
			s_d.run_pulse = 1'b1;
			s_d.run_pend = 1'b0;
		end
		case (s_q.st)
			FBT_IDLE: begin
				if (s_q.op != FBT_OP_NONE &&
						(s_q.edge_mode ? s_q.pend : s_q.cond)) begin
					s_d.pend = 1'b0;
					s_d.st = FBT_CHECK;
				end
			end
			FBT_CHECK: begin
				if (bad != '0) begin
					s_d.ferr = s_d.ferr | bad;
					s_d.err = 1'b1;
					err_set = 1'b1;
					s_d.st = FBT_IDLE;
				end else begin
					s_d.active = 1'b1;
					s_d.dir = (s_q.op != FBT_OP_WRITE);
					s_d.blk = blk_bin[10:0];
					s_d.left = (s_q.op == FBT_OP_LOAD) ? '0 : n_bin;
					s_d.wptr = eff_addr;
					s_d.run_addr = eff_addr;
					s_d.word = '0;
					s_d.cnt_ld = 1'b1;
					s_d.first = 1'b1;
					s_d.end_seen = 1'b0;
					s_d.abort = 1'b0;
					s_d.st = (s_q.op != FBT_OP_LOAD && n_bin == '0) ?
						FBT_DONE : FBT_BSTART;
				end
			end
			FBT_BSTART: begin
				if (s_q.op == FBT_OP_LOAD &&
						17'(s_q.wptr) + 17'(BLOCK_WORDS) > 17'(PM_WORDS)) begin
					s_d.ferr[FE_MEM] = 1'b1;
					s_d.err = 1'b1;
					err_set = 1'b1;
					s_d.abort = 1'b1;
					s_d.st = FBT_DONE;
				end else begin
					s_d.st = FBT_SRC;
				end
			end
			FBT_SRC: begin
				if (s_q.op == FBT_OP_WRITE) begin
					if (17'(s_q.wptr) >= 17'(DM_WORDS)) begin
						s_d.data = '0;
						s_d.st = FBT_DST;
					end else begin
						s_d.wm_req = 1'b1;
						s_d.wm_we = 1'b0;
						s_d.wm_space = 1'b0;
						s_d.wm_addr = s_q.wptr;
						s_d.st = FBT_SWAIT;
					end
				end else begin
					s_d.fm_req = 1'b1;
					s_d.fm_we = 1'b0;
					s_d.fm_addr = {s_q.blk, s_q.word};
					s_d.st = FBT_SWAIT;
				end
			end
			FBT_SWAIT: begin
				if (s_q.op == FBT_OP_WRITE) begin
					if (wm_ack) begin
						s_d.wm_req = 1'b0;
						s_d.data = wm_rdata;
						s_d.st = FBT_DST;
					end
				end else if (fm_ack) begin
					s_d.fm_req = 1'b0;
					s_d.data = fm_rdata;
					if (s_q.op == FBT_OP_LOAD && s_q.word == '0 &&
							!s_q.first && !fm_rprog) begin
						s_d.st = FBT_DONE;
					end else begin
						if (s_q.op == FBT_OP_LOAD && fm_rdata == END_WORD) begin
							s_d.end_seen = 1'b1;
						end
						s_d.st = FBT_DST;
					end
				end
			end
			FBT_DST: begin
				if (s_q.op == FBT_OP_WRITE) begin
					s_d.fm_req = 1'b1;
					s_d.fm_we = 1'b1;
					s_d.fm_addr = {s_q.blk, s_q.word};
					s_d.fm_wdata = s_q.data;
					s_d.st = FBT_DWAIT;
				end else if (s_q.op == FBT_OP_READ &&
						17'(s_q.wptr) >= 17'(DM_WORDS)) begin
					s_d.st = FBT_NEXT;
				end else begin
					s_d.wm_req = 1'b1;
					s_d.wm_we = 1'b1;
					s_d.wm_space = (s_q.op == FBT_OP_LOAD);
					s_d.wm_addr = s_q.wptr;
					s_d.wm_wdata = s_q.data;
					s_d.st = FBT_DWAIT;
				end
			end
			FBT_DWAIT: begin
				if (s_q.op == FBT_OP_WRITE ? fm_ack : wm_ack) begin
					s_d.fm_req = 1'b0;
					s_d.wm_req = 1'b0;
					s_d.st = FBT_NEXT;
				end
			end
			FBT_NEXT: begin
				s_d.word = s_q.word + 7'd1;
				s_d.wptr = (s_q.wptr == 16'hFFFF) ? s_q.wptr : s_q.wptr + 16'd1;
				if (s_q.op == FBT_OP_READ && fail_s) begin
					s_d.abort = 1'b1;
					s_d.err = 1'b1;
					err_set = 1'b1;
					s_d.st = FBT_DONE;
				end else begin
					s_d.st = (s_q.word == LAST_WORD) ? FBT_BLK : FBT_SRC;
				end
			end
			FBT_BLK: begin
				s_d.cnt_step = 1'b1;
				s_d.first = 1'b0;
				s_d.blk = s_q.blk + 11'd1;
				if (s_q.op != FBT_OP_LOAD) begin
					s_d.left = s_q.left - 14'd1;
				end
				if (s_q.op == FBT_OP_WRITE && fail_s) begin
					s_d.abort = 1'b1;
					s_d.err = 1'b1;
					err_set = 1'b1;
					s_d.st = FBT_DONE;
				end else if (s_q.op == FBT_OP_LOAD) begin
					s_d.st = (s_q.end_seen || s_q.blk == max_blk) ?
						FBT_DONE : FBT_BSTART;
				end else begin
					s_d.st = (s_q.left == 14'd1) ? FBT_DONE : FBT_BSTART;
				end
			end
			FBT_DONE: begin
				s_d.active = 1'b0;
				if (s_q.op == FBT_OP_LOAD && !s_q.abort) begin
					s_d.run_pend = 1'b1;
				end
				s_d.st = FBT_IDLE;
			end
			default: s_d.st = FBT_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign fm_req = s_q.fm_req;
	assign fm_we = s_q.fm_we;
	assign fm_addr = s_q.fm_addr;
	assign fm_wdata = s_q.fm_wdata;
	assign wm_req = s_q.wm_req;
	assign wm_we = s_q.wm_we;
	assign wm_space = s_q.wm_space;
	assign wm_addr = s_q.wm_addr;
	assign wm_wdata = s_q.wm_wdata;
	assign run_loaded = s_q.run_pulse;
	assign run_addr = s_q.run_addr;
	assign xfer_active = s_q.active;
	assign xfer_dir = s_q.dir;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_absent_check;
		s_q.st == FBT_CHECK && !present_s;
	endsequence

	sequence s_good_check;
		s_q.st == FBT_CHECK && bad == '0;
	endsequence

	property p_active_on;
		@(posedge pclk) disable iff (!presetn)
		s_good_check |=> xfer_active;
	endproperty
	a_active_on: assert property (p_active_on) else $error("active not set");

	property p_dir;
		@(posedge pclk) disable iff (!presetn)
		s_good_check |=> xfer_dir == (s_q.op != FBT_OP_WRITE);
	endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		(s_q.clr_prev && !s_q.clr && !err_set) |=> s_q.ferr == '0 && !s_q.err;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");

	property p_absent;
		@(posedge pclk) disable iff (!presetn)
		s_absent_check |=> s_q.ferr[FE_ABSENT] && s_q.err &&
			s_q.st == FBT_IDLE ##1 !fm_req[*2];
	endproperty
	a_absent: assert property (p_absent) else $error("absent unit ran");

	property p_max_blk;
		@(posedge pclk) disable iff (!presetn)
		fm_req |-> fm_addr[17:7] <= max_blk;
	endproperty
	a_max_blk: assert property (p_max_blk) else $error("block past end");

	property p_trunc;
		@(posedge pclk) disable iff (!presetn)
		(wm_req && wm_we && !wm_space) |-> 17'(wm_addr) < 17'(DM_WORDS);
	endproperty
	a_trunc: assert property (p_trunc) else $error("write past area");

	property p_edge_once;
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == FBT_IDLE && s_q.edge_mode && !s_q.pend && s_q.cond &&
			s_q.cond_prev) |=> s_q.st == FBT_IDLE;
	endproperty
	a_edge_once: assert property (p_edge_once) else $error("edge retrigger");

	property p_block_step;
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == FBT_BLK && s_q.op == FBT_OP_READ) |=>
			s_q.cnt_step ##1 (done_cnt == fbt_bcd_step($past(done_cnt, 2), 1'b1));
	endproperty
	a_block_step: assert property (p_block_step) else $error("count step");

	property p_run_hold;
		@(posedge pclk) disable iff (!presetn)
		run_loaded |-> s_q.edge_mode || !s_q.cond;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("ran under cond");

endmodule // fbt_engine

// ### fbt_mem_model.sv
`timescale 1ns/1ps
module fbt_mem_model
	import fbt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic slow,
	input wire logic [17:0] end_addr,
	input wire logic fm_req,
	input wire logic fm_we,
	input wire logic [17:0] fm_addr,
	input wire logic [15:0] fm_wdata,
	output logic [15:0] fm_rdata,
	output logic fm_rprog,
	output logic fm_ack,
	input wire logic wm_req,
	input wire logic wm_we,
	input wire logic wm_space,
	input wire logic [15:0] wm_addr,
	output logic [15:0] wm_rdata,
	output logic wm_ack,
	output int n_frd,
	output int n_fwr,
	output int n_zero,
	output int n_dwr,
	output int n_pwr,
	output logic [10:0] blk1
);
	logic [2:0] fw_q;
	logic f1_q;
	assign fm_rprog = fm_ack && fm_addr[17:7] != end_addr[17:7];
	// ********
	// Memory responders
	// ********
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fm_ack <= 1'b0;
			wm_ack <= 1'b0;
			fw_q <= 3'h0;
			fm_rdata <= 16'h0000;
			wm_rdata <= 16'h0000;
		end else begin
			fm_ack <= 1'b0;
			wm_ack <= 1'b0;
			fm_rdata <= ~fm_rdata;
			wm_rdata <= ~wm_rdata;
			if (clr) begin
				n_frd <= 0;
				n_fwr <= 0;
				n_zero <= 0;
				n_dwr <= 0;
				n_pwr <= 0;
				f1_q <= 1'b1;
			end
			if (fm_req && !fm_ack) begin
				fw_q <= fw_q + 3'h1;
				if (fw_q >= {slow, 2'h0}) begin
					fw_q <= 3'h0;
					fm_ack <= 1'b1;
					if (fm_we) begin
						n_fwr <= n_fwr + 1;
						n_zero <= n_zero + int'(fm_wdata == 16'h0000);
						f1_q <= 1'b0;
						if (f1_q)
							blk1 <= fm_addr[17:7];
					end else begin
						n_frd <= n_frd + 1;
						fm_rdata <= (fm_addr == end_addr) ? END_WORD_DEF :
							{1'b1, fm_addr[14:0]};
					end
				end
			end
			if (wm_req && !wm_ack) begin
				wm_ack <= 1'b1;
				wm_rdata <= {1'b1, wm_addr[14:0]};
				if (wm_we && wm_space)
					n_pwr <= n_pwr + 1;
				if (wm_we && !wm_space)
					n_dwr <= n_dwr + 1;
			end
		end
	end
endmodule // fbt_mem_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import fbt_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic fm_present, fm_fail, fm_req, fm_we, fm_rprog, fm_ack, clr, slow;
	logic [17:0] fm_addr, end_addr;
	logic [15:0] fm_wdata, fm_rdata, wm_addr, wm_wdata, wm_rdata, run_addr;
	logic wm_req, wm_we, wm_space, wm_ack, run_loaded, xfer_active, xfer_dir;
	logic [10:0] blk1;
	logic lvl = 1'b0;
	int n_frd, n_fwr, n_zero, n_dwr, n_pwr, runs, bad_count, comparisons;
	logic [1:0] eop[6] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h3, 2'h1};
	logic [15:0] ecfg[6] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h2, 16'h4};
	logic [15:0] ecnt[6] = '{16'h1, 16'hA1, 16'h2, 16'h2, 16'h0, 16'h1};
	logic [15:0] eblk[6] = '{16'h0, 16'h0, 16'h999, 16'h1999, 16'h0, 16'h0};
	logic [15:0] ewd[6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hF0};
	logic epr[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	logic [4:0] eexp[6] = '{5'h11, 5'h12, 5'h14, 5'h14, 5'h18, 5'h18};

	fbt_engine #(.DM_WORDS(256)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fm_present,
		.fm_fail, .fm_req, .fm_we, .fm_addr, .fm_wdata, .fm_rdata, .fm_rprog,
		.fm_ack, .wm_req, .wm_we, .wm_space, .wm_addr, .wm_wdata, .wm_rdata,
		.wm_ack, .run_loaded, .run_addr, .xfer_active, .xfer_dir);
	fbt_mem_model model (.pclk, .presetn, .clr, .slow, .end_addr, .fm_req,
		.fm_we, .fm_addr, .fm_wdata, .fm_rdata, .fm_rprog, .fm_ack, .wm_req,
		.wm_we, .wm_space, .wm_addr, .wm_rdata, .wm_ack, .n_frd, .n_fwr,
		.n_zero, .n_dwr, .n_pwr, .blk1);

	always #10 pclk = ~pclk;
	always @(posedge pclk) if (run_loaded === 1'b1) runs <= runs + 1;

	// ********
	// Checking and bus tasks
	// ********
	task check(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task complete_run;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task bound;
		bad_count++;
		$display("MISMATCH wait expected end seen bound");
		complete_run();
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) bound();
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(nm, rd, e);
	endtask
	task wait_act(input logic v);
		int n;
		n = 0;
		while (xfer_active !== v) begin
			cyc(1);
			n++;
			if (n > 40000) bound();
		end
	endtask
	task go(input logic [1:0] op, input logic [15:0] c, n, b, w);
		wr(OFS_CFG, {16'h0, c});
		wr(OFS_COUNT, {16'h0, n});
		wr(OFS_BLOCK, {16'h0, b});
		wr(OFS_WORD, {16'h0, w});
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		wr(OFS_CMD, {30'h0, op});
		cyc(10);
		check("idle", n_frd + n_fwr, 0);
		wr(OFS_CMD, {28'h0, 1'b0, !lvl, op});
		wr(OFS_CMD, {28'h0, 1'b1, !lvl, op});
	endtask
	task xfer(input logic dir);
		wait_act(1'b1);
		check("dir", xfer_dir, dir);
		wait_act(1'b0);
		cyc(20);
		check("once", xfer_active, 0);
		wr(OFS_CMD, 32'h0);
	endtask
	task clear;
		wr(OFS_STATUS, 32'h1);
		wr(OFS_STATUS, 32'h0);
		cyc(3);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("cleared", rd[7:3], 0);
	endtask

	// ********
	// Scenarios
	// ********
	task t_reset;
		rdc("status", OFS_STATUS, {16'h0, RST_WORD});
		rdc("done", OFS_DONE, 0);
		rdc("left", OFS_LEFT, 0);
		rdc("unmapped", 8'h20, 0);
		check("slverr", er, 1);
		$display("test reset ended");
	endtask
	task t_read;
		slow <= 1'b1;
		go(FBT_OP_READ, 16'h0, 16'h2, 16'h5, 16'h0);
		xfer(1'b1);
		check("reads", n_frd, 256);
		check("dm_writes", n_dwr, 256);
		rdc("done", OFS_DONE, 32'h2);
		rdc("left", OFS_LEFT, 32'h0);
		slow <= 1'b0;
		go(FBT_OP_READ, 16'h0, 16'h1, 16'h0, 16'hE0);
		xfer(1'b1);
		check("reads", n_frd, 128);
		check("fit", n_dwr, 32);
		$display("test read ended");
	endtask
	task t_write;
		go(FBT_OP_WRITE, 16'h0, 16'h10, 16'h990, 16'h0);
		xfer(1'b0);
		check("writes", n_fwr, 1280);
		check("empty", n_zero, 1024);
		check("first_blk", blk1, 990);
		rdc("done", OFS_DONE, 32'h10);
		rdc("left", OFS_LEFT, 32'h0);
		$display("test write ended");
	endtask
	task t_err;
		for (int i = 0; i < 6; i++) begin
			fm_present <= epr[i];
			cyc(4);
			go(eop[i], ecfg[i], ecnt[i], eblk[i], ewd[i]);
			cyc(10);
			apb(1'b0, OFS_STATUS, 32'h0);
			check("err", rd[7:3], eexp[i]);
			check("no_xfer", n_frd + n_fwr, 0);
			wr(OFS_CMD, 32'h0);
			clear();
		end
		fm_present <= 1'b1;
		cyc(4);
		$display("test errors ended");
	endtask
	task t_fail;
		go(FBT_OP_READ, 16'h0, 16'h2, 16'h0, 16'h0);
		wait_act(1'b1);
		cyc(300);
		fm_fail <= 1'b1;
		wait_act(1'b0);
		cyc(5);
		check("word_done", n_dwr, n_frd);
		check("stopped", n_frd < 256, 1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("fail_err", rd[7], 1);
		fm_fail <= 1'b0;
		wr(OFS_CMD, 32'h0);
		clear();
		go(FBT_OP_WRITE, 16'h0, 16'h2, 16'h0, 16'h0);
		wait_act(1'b1);
		cyc(300);
		fm_fail <= 1'b1;
		wait_act(1'b0);
		cyc(5);
		check("blk_done", n_fwr, 128);
		fm_fail <= 1'b0;
		wr(OFS_CMD, 32'h0);
		clear();
		$display("test failure ended");
	endtask
	task t_load;
		end_addr <= {11'd10, 7'd5};
		go(FBT_OP_LOAD, 16'h0, 16'h0, 16'h10, 16'h0);
		xfer(1'b1);
		check("prog", n_pwr, 128);
		check("run", runs, 1);
		check("run_addr", run_addr, 0);
		lvl = 1'b1;
		end_addr <= {11'd12, 7'd0};
		go(FBT_OP_LOAD, 16'h0, 16'h0, 16'h10, 16'h0);
		wait_act(1'b1);
		wait_act(1'b0);
		check("nonprog", n_pwr, 256);
		wr(OFS_CMD, 32'h3);
		check("hold", runs, 1);
		wait_act(1'b0);
		cyc(20);
		check("level_run", runs, 3);
		$display("test load ended");
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fm_present = 1'b1;
		fm_fail = 1'b0;
		clr = 1'b0;
		slow = 1'b0;
		end_addr = 18'h3FFFF;
		runs = 0;
		bad_count = 0;
		comparisons = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		cyc(3);
		t_reset();
		t_read();
		t_write();
		t_err();
		t_fail();
		t_load();
		complete_run();
	end
endmodule // tb_top
